/* File: hw/ubt_pkg.sv */
// Shared constants of the serial port: register map, field positions,
// reset values and divide factors.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
package ubt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Indices are word numbers; the byte address is four times the index.
  localparam int          ADR_W   = 12;
  localparam logic [9:0]  IDX_TXC = 10'h098;
  localparam logic [9:0]  IDX_RXC = 10'h018;
  localparam logic [9:0]  IDX_DIV = 10'h099;
  localparam logic [9:0]  IDX_TXD = 10'h019;
  localparam logic [9:0]  IDX_DIR = 10'h086;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TXC_CLK_SRC = 7;
  localparam int TXC_NINE    = 6;
  localparam int TXC_TRANSMIT_ENABLE_BIT    = 5;
  localparam int TXC_SYNC    = 4;
  localparam int TXC_HIGH    = 2;
  localparam int TXC_EMPTY   = 1;
  localparam int TXC_NINTH   = 0;
  localparam int RXC_SERIAL_PORT_ENABLE    = 7;
  localparam int RXC_SINGLE_RECEIVE_ENABLE    = 5;
  localparam int RXC_CONTINUOUS_RECEIVE_ENABLE    = 4;
  localparam int DIR_RX      = 1;
  localparam int DIR_CK      = 2;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] TXC_RST   = 8'h02;
  localparam logic [7:0] TXC_WMASK = 8'hF5;
  localparam logic [7:0] RXC_RST   = 8'h00;
  localparam logic [7:0] DIV_RST   = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;

  // ****************************************************************
  // Generator ticks per bit and data bits per character, stored as last counts
  // ****************************************************************
  localparam logic [5:0] LOW_LAST  = 6'h3F;
  localparam logic [5:0] HIGH_LAST = 6'h0F;
  localparam logic [5:0] SYNC_LAST = 6'h03;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubt_tx_e;

  function automatic logic [ADR_W-1:0] ubt_adr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

/* File: hw/ubt_strm_if.sv */
// Valid/ready word stream between the bus side and the transmitter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface ubt_strm_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hw/ubt_buf2.sv */
// Two-entry buffer holding transmit words until the shifter takes them.
// Assumes source and sink follow valid/ready on the same clock.
`timescale 1ns/1ps
module ubt_buf2 #(
  parameter int W = 9
) (
  input  wire logic clock,
  input  wire logic rst,
  ubt_strm_if.snk   in_s,
  ubt_strm_if.src   out_s
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  logic         next_wp;
  logic         next_rp;
  logic [1:0]   next_cnt;
  logic         push;
  logic         pop;

  assign in_s.ready  = (cnt != 2'h2);
  assign out_s.valid = (cnt != 2'h0);
  assign out_s.data  = mem[rp];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    next_mem = mem;
    next_wp  = wp;
    next_rp  = rp;
    next_cnt = cnt;
    if (push) begin
      next_mem[wp] = in_s.data;
      next_wp      = ~wp;
    end
    if (pop) begin
      next_rp = ~rp;
    end
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    mem <= next_mem;
    if (rst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  a_buf_no_overfill: assert property (@(posedge clock) disable iff (rst)
    cnt == 2'h2 |-> !in_s.ready) else $error("buffer accepts while full");

endmodule

/* File: hw/ubt_rate_gen.sv */
// Free-running rate timer: one tick every divisor+1 clock cycles.
// Assumes clear is a one-cycle pulse from a divisor write.
`timescale 1ns/1ps
module ubt_rate_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_tick;

  always_comb begin
    next_tick = 1'b0;
    if (clear) begin
      next_cnt = '0;
    end else if (cnt >= divisor) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  a_div_clear: assert property (@(posedge clock) disable iff (rst)
    clear |=> cnt == '0 && !tick) else $error("divisor write did not clear timer");
  a_tick_period: assert property (@(posedge clock) disable iff (rst)
    tick && !$past(clear) && $stable(divisor) |-> $past(cnt) == divisor)
    else $error("tick not at divisor count");

endmodule

/* File: hw/ubt_top.sv */
// Serial port transmit control, mode selection and rate generation.
// Assumes a classic Wishbone master and pins resolved outside from enables.
//
// Operation
// - Pins serve the port only with port enable and both direction bits set.
// - Modes: asynchronous full duplex, synchronous master, synchronous slave.
// - Mode select bit set means synchronous, cleared means asynchronous.
// - One dedicated 8-bit rate generator serves the asynchronous and synchronous master modes.
// - Divisor register sets the period of the free-running 8-bit timer.
// - Asynchronous mode: high rate select picks the divide factor.
// - Synchronous mode ignores high rate select.
// - Asynchronous low speed: bit rate is clock over 64 times divisor plus one.
// - Asynchronous high speed: bit rate is clock over 16 times divisor plus one.
// - Formulas hold with own clock; slave takes its bit clock from outside.
// - Writing the divisor clears the timer at once.
// - Receive pin level is a majority vote of three samples.
// - Synchronous master bit clock is clock over 4 times divisor plus one.
// - Divisor is the unsigned register value, zero through 255.
`timescale 1ns/1ps
module ubt_top
  import ubt_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             dt_i,
  output logic                  dt_o,
  output logic                  dt_oe,
  input  wire logic             ck_i,
  output logic                  ck_o,
  output logic                  ck_oe,
  output logic                  rx_level
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]  txc;
  logic [7:0]  rxc;
  logic [7:0]  div;
  logic [7:0]  dir;
  logic [7:0]  next_txc;
  logic [7:0]  next_rxc;
  logic [7:0]  next_div;
  logic [7:0]  next_dir;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        req;
  logic        wr;
  logic        div_wr;
  logic        shift_empty;

  ubt_strm_if #(.W(9)) push_s ();
  ubt_strm_if #(.W(9)) pop_s ();

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];
  assign push_s.valid = wr && (wb_adr_i == ubt_adr(IDX_TXD));
  assign push_s.data  = {txc[TXC_NINTH], wb_dat_i[7:0]};

  always_comb begin
    next_txc = txc;
    next_rxc = rxc;
    next_div = div;
    next_dir = dir;
    next_dat = wb_dat_o;
    next_ack = 1'b0;
    div_wr   = 1'b0;
    if (req) begin
      // A data write waits here while the buffer is full.
      next_ack = (wb_we_i && wb_adr_i == ubt_adr(IDX_TXD)) ? push_s.ready : 1'b1;
      next_dat = 32'h0000_0000;
    end
    if (wr && next_ack) begin
      if (wb_adr_i == ubt_adr(IDX_TXC)) begin
        next_txc = wb_dat_i[7:0] & TXC_WMASK;
      end else if (wb_adr_i == ubt_adr(IDX_RXC)) begin
        next_rxc = wb_dat_i[7:0];
      end else if (wb_adr_i == ubt_adr(IDX_DIV)) begin
        next_div = wb_dat_i[7:0];
        div_wr   = 1'b1;
      end else if (wb_adr_i == ubt_adr(IDX_DIR)) begin
        next_dir = wb_dat_i[7:0];
      end
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i == ubt_adr(IDX_TXC)) begin
        next_dat[7:0] = {txc[7:4], 1'b0, txc[TXC_HIGH], shift_empty, txc[TXC_NINTH]};
      end else if (wb_adr_i == ubt_adr(IDX_RXC)) begin
        next_dat[7:0] = rxc;
      end else if (wb_adr_i == ubt_adr(IDX_DIV)) begin
        next_dat[7:0] = div;
      end else if (wb_adr_i == ubt_adr(IDX_DIR)) begin
        next_dat[7:0] = dir;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txc      <= TXC_RST & TXC_WMASK;
      rxc      <= RXC_RST;
      div      <= DIV_RST;
      dir      <= DIR_RST;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      txc      <= next_txc;
      rxc      <= next_rxc;
      div      <= next_div;
      dir      <= next_dir;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  // ****************************************************************
  // Rate generator and buffer
  // ****************************************************************
  logic tick;

  ubt_rate_gen #(.DIV_W(8)) u_gen (
    .clock   (clock),
    .rst     (rst),
    .clear   (div_wr),
    .divisor (div),
    .tick    (tick)
  );

  ubt_buf2 #(.W(9)) u_buf (
    .clock (clock),
    .rst   (rst),
    .in_s  (push_s),
    .out_s (pop_s)
  );

  // ****************************************************************
  // Pin synchronisers and receive majority vote
  // ****************************************************************
  logic       dt_s1;
  logic       dt_s2;
  logic       ck_s1;
  logic       ck_s2;
  logic       ck_s3;
  logic [2:0] vote;

  always_ff @(posedge clock) begin
    if (rst) begin
      dt_s1    <= 1'b1;
      dt_s2    <= 1'b1;
      ck_s1    <= 1'b0;
      ck_s2    <= 1'b0;
      ck_s3    <= 1'b0;
      vote     <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      dt_s1 <= dt_i;
      dt_s2 <= dt_s1;
      ck_s1 <= ck_i;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      // Sampling on generator ticks keeps the vote window tied to the bit rate.
      if (tick) begin
        vote <= {vote[1:0], dt_s2};
      end
      rx_level <= (vote[0] & vote[1]) | (vote[1] & vote[2]) | (vote[0] & vote[2]);
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  ubt_tx_e    state;
  ubt_tx_e    next_state;
  logic [8:0] shreg;
  logic [8:0] next_shreg;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [5:0] ps;
  logic [5:0] next_ps;
  logic [5:0] ps_last;
  logic [3:0] bit_last;
  logic       next_line;
  logic       next_dt_oe;
  logic       next_ck_o;
  logic       next_ck_oe;
  logic       sync_m;
  logic       master;
  logic       slave;
  logic       pins_on;
  logic       rx_on;
  logic       tx_go;
  logic       step;
  logic       load_ok;

  assign sync_m   = txc[TXC_SYNC];
  assign master   = txc[TXC_CLK_SRC];
  assign slave    = sync_m & ~master;
  assign pins_on  = rxc[RXC_SERIAL_PORT_ENABLE] & dir[DIR_CK] & dir[DIR_RX];
  assign rx_on    = rxc[RXC_SINGLE_RECEIVE_ENABLE] | rxc[RXC_CONTINUOUS_RECEIVE_ENABLE];
  assign tx_go    = pins_on & txc[TXC_TRANSMIT_ENABLE_BIT] & ~(sync_m & rx_on);
  assign bit_last = txc[TXC_NINE] ? LAST_BIT9 : LAST_BIT8;
  assign shift_empty = (state == TX_IDLE);
  assign load_ok  = slave ? 1'b1 : step;
  assign pop_s.ready = (state == TX_IDLE) && tx_go && load_ok;

  always_comb begin
    if (sync_m) begin
      ps_last = SYNC_LAST;
    end else if (txc[TXC_HIGH]) begin
      ps_last = HIGH_LAST;
    end else begin
      ps_last = LOW_LAST;
    end
  end

  // The slave advances on the outside clock's falling edge, not on ticks.
  assign step = slave ? (ck_s3 & ~ck_s2) : (tick && ps >= ps_last);

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_line  = dt_o;
    next_ps    = ps;
    if (div_wr || (wr && wb_adr_i == ubt_adr(IDX_TXC))) begin
      next_ps = 6'h00;
    end else if (tick) begin
      next_ps = (ps >= ps_last) ? 6'h00 : ps + 6'h01;
    end
    case (state)
      TX_IDLE: begin
        next_line = 1'b1;
        if (pop_s.valid && pop_s.ready) begin
          next_shreg = pop_s.data;
          next_cnt   = 4'h0;
          next_state = sync_m ? TX_DATA : TX_START;
          next_line  = sync_m ? pop_s.data[0] : 1'b0;
        end
      end
      TX_START: begin
        if (step) begin
          next_state = TX_DATA;
          next_line  = shreg[0];
        end
      end
      TX_DATA: begin
        if (step) begin
          if (cnt == bit_last) begin
            next_state = sync_m ? TX_IDLE : TX_STOP;
            next_line  = 1'b1;
          end else begin
            next_shreg = {1'b0, shreg[8:1]};
            next_cnt   = cnt + 4'h1;
            next_line  = shreg[1];
          end
        end
      end
      default: begin
        if (step) begin
          next_state = TX_IDLE;
        end
      end
    endcase
    // Dropping the enable abandons the word in the shifter.
    if (!tx_go) begin
      next_state = TX_IDLE;
      next_line  = 1'b1;
    end
    if (sync_m) begin
      next_ck_o  = master && next_state != TX_IDLE && next_ps[1];
      next_ck_oe = pins_on & master;
      next_dt_oe = pins_on & tx_go;
    end else begin
      next_ck_o  = next_line;
      next_ck_oe = pins_on;
      next_dt_oe = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= TX_IDLE;
      shreg <= 9'h000;
      cnt   <= 4'h0;
      ps    <= 6'h00;
      dt_o  <= 1'b1;
      dt_oe <= 1'b0;
      ck_o  <= 1'b1;
      ck_oe <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt   <= next_cnt;
      ps    <= next_ps;
      dt_o  <= next_line;
      dt_oe <= next_dt_oe;
      ck_o  <= next_ck_o;
      ck_oe <= next_ck_oe;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pins_gated: assert property (!pins_on |=> !ck_oe && !dt_oe)
    else $error("pins driven while port disabled");
  a_async_no_dt: assert property (!sync_m |=> !dt_oe)
    else $error("data pin driven in asynchronous mode");
  a_nine_bits: assert property (state == TX_DATA && step && tx_go && cnt == bit_last
    |=> state == (sync_m ? TX_IDLE : TX_STOP)) else $error("wrong character length");
  a_low_factor: assert property (!sync_m && !txc[TXC_HIGH] && step |-> ps == 6'h3F)
    else $error("low speed factor wrong");
  a_high_factor: assert property (!sync_m && txc[TXC_HIGH] && step |-> ps == 6'h0F)
    else $error("high speed factor wrong");
  a_sync_factor: assert property (sync_m && master && step |-> ps == 6'h03)
    else $error("sync master factor wrong");
  a_slave_ext: assert property (slave && step |-> $past(ck_s2) && !ck_s2)
    else $error("slave step without outside clock edge");
  a_rx_override: assert property (sync_m && rx_on |=> state == TX_IDLE)
    else $error("receive enable did not stop transmit");
  a_empty_flag: assert property (pop_s.valid && pop_s.ready |=> !shift_empty ##0
    state != TX_IDLE) else $error("empty flag set after load");
  a_vote_high: assert property (vote == 3'h7 |=> rx_level)
    else $error("majority high lost");
  a_vote_low: assert property (vote == 3'h0 |=> !rx_level)
    else $error("majority low lost");
  a_slave_no_ck: assert property (sync_m && !master |=> !ck_oe)
    else $error("slave drives clock pin");

  c_async_word: cover property (state == TX_STOP && step);
  c_sync_master: cover property (sync_m && master && state == TX_DATA && step);
  c_sync_slave: cover property (slave && state == TX_DATA && step);
  c_buffer_stall: cover property (push_s.valid && !push_s.ready);

endmodule

/* File: tb/ubt_peer.sv */
// Behavioural serial peer that receives asynchronous frames from the port.
// Assumes the line idles high, a frame starts with a low start bit and data bit 0 is one.
`timescale 1ns/1ps
module ubt_peer (
  input  wire logic clock,
  input  wire logic line,
  input  wire logic nine,
  output logic [8:0] word,
  output logic       stop_bit,
  output int         start_len,
  output int         frames
);
  int n;
  int nb;

  // ****************************************************************
  // Frame capture
  // ****************************************************************
  // The bit time is learnt from the start bit, so data bit 0 must be one.
  initial begin
    frames = 0;
    word = '0;
    stop_bit = 1'b0;
    start_len = 0;
    forever begin
      @(posedge clock);
      if (line === 1'b0) begin
        n = 0;
        while (line === 1'b0 && n < 100000) begin
          @(posedge clock);
          n++;
        end
        start_len = n;
        nb = nine ? 9 : 8;
        repeat (n / 2) @(posedge clock);
        word = '0;
        for (int i = 0; i < nb; i++) begin
          word[i] = line;
          repeat (n) @(posedge clock);
        end
        stop_bit = line;
        frames++;
      end
    end
  end
endmodule

/* File: tb/ubt_top_bench.sv */
// Self-checking bench for the serial port transmit control and rate generator.
// Assumes the design files and the peer model are compiled before it.
`timescale 1ns/1ps
module ubt_top_bench;
  import ubt_pkg::*;
  localparam logic [ADR_W-1:0] A_TXC = {IDX_TXC, 2'b00};
  localparam logic [ADR_W-1:0] A_RXC = {IDX_RXC, 2'b00};
  localparam logic [ADR_W-1:0] A_DIV = {IDX_DIV, 2'b00};
  localparam logic [ADR_W-1:0] A_TXD = {IDX_TXD, 2'b00};
  localparam logic [ADR_W-1:0] A_DIR = {IDX_DIR, 2'b00};
  localparam logic [ADR_W-1:0] A_BAD = 12'h7F0;

  logic             clock;
  logic             rst;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [31:0]      dat_w;
  logic [31:0]      dat_r;
  logic             ack;
  logic             dt_i;
  logic             dt_o;
  logic             dt_oe;
  logic             ck_i;
  logic             ck_o;
  logic             ck_oe;
  logic             rx_level;
  logic             rx_drv;
  logic             ck_drv;
  logic             p_nine;
  logic [8:0]       p_word;
  logic             p_stop;
  int               p_start;
  int               p_frames;
  int               fail_count;
  int               check_count;
  logic [7:0]       q;

  // Both pins are resolved from the enables; an undriven pin follows the bench's source.
  assign dt_i = dt_oe ? dt_o : rx_drv;
  assign ck_i = ck_oe ? ck_o : ck_drv;

  ubt_top uut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .dt_i(dt_i), .dt_o(dt_o), .dt_oe(dt_oe), .ck_i(ck_i), .ck_o(ck_o), .ck_oe(ck_oe),
    .rx_level(rx_level));

  ubt_peer peer (.clock(clock), .line(ck_i), .nine(p_nine), .word(p_word),
    .stop_bit(p_stop), .start_len(p_start), .frames(p_frames));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 4000);
    chk("bus acknowledge", 1, ack);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic take_frame(input int cnt, input logic [8:0] w, input int bl);
    int n;
    n = 0;
    while (p_frames < cnt && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk("frame arrived", 1, p_frames >= cnt);
    chk("start bit length", bl, p_start);
    chk("frame data", w, p_word);
    chk("stop bit", 1, p_stop);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    wb(1'b0, A_TXC, 8'h00);
    chk("tx control reset", TXC_RST, q);
    wb(1'b0, A_RXC, 8'h00);
    chk("rx control reset", RXC_RST, q);
    wb(1'b0, A_DIV, 8'h00);
    chk("divisor reset", DIV_RST, q);
    wb(1'b0, A_DIR, 8'h00);
    chk("direction reset", DIR_RST, q);
    chk("rx level reset", 1, rx_level);
    chk("clock pin enable reset", 0, ck_oe);
  endtask

  task automatic t_regs;
    wb(1'b1, A_TXC, 8'hFF);
    wb(1'b0, A_TXC, 8'h00);
    chk("tx control masked", 8'hF7, q);
    wb(1'b1, A_TXC, 8'h00);
    wb(1'b1, A_DIV, 8'hFF);
    wb(1'b1, A_BAD, 8'h55);
    wb(1'b0, A_BAD, 8'h00);
    chk("unmapped read", 0, q);
    wb(1'b0, A_DIV, 8'h00);
    chk("divisor full range", 8'hFF, q);
  endtask

  task automatic t_async_low;
    wb(1'b1, A_DIV, 8'h01);
    wb(1'b1, A_TXC, 8'h61);
    wb(1'b1, A_RXC, 8'h80);
    repeat (3) @(posedge clock);
    chk("pin off without direction", 0, ck_oe);
    wb(1'b1, A_DIR, 8'h06);
    repeat (3) @(posedge clock);
    chk("pin on with direction", 1, ck_oe);
    chk("data pin released in async", 0, dt_oe);
    p_nine <= 1'b1;
    wb(1'b1, A_TXD, 8'hA5);
    repeat (130) @(posedge clock);
    wb(1'b0, A_TXC, 8'h00);
    chk("empty flag while loaded", 8'h61, q);
    take_frame(1, 9'h1A5, 128);
    repeat (200) @(posedge clock);
    wb(1'b0, A_TXC, 8'h00);
    chk("empty flag after frame", 8'h63, q);
  endtask

  task automatic t_async_high;
    // High speed is the finer choice even at low rates.
    wb(1'b1, A_TXC, 8'h24);
    p_nine <= 1'b0;
    wb(1'b1, A_DIV, 8'h00);
    wb(1'b1, A_TXD, 8'h5B);
    wb(1'b1, A_TXD, 8'hC3);
    wb(1'b1, A_TXD, 8'h81);
    take_frame(2, 9'h05B, 16);
    take_frame(3, 9'h0C3, 16);
    take_frame(4, 9'h081, 16);
  endtask

  task automatic t_majority;
    rx_drv <= 1'b0;
    repeat (8) @(posedge clock);
    chk("rx level low", 0, rx_level);
    rx_drv <= 1'b1;
    @(posedge clock);
    rx_drv <= 1'b0;
    repeat (8) begin
      @(posedge clock);
      chk("rx level ignores glitch", 0, rx_level);
    end
    rx_drv <= 1'b1;
    repeat (8) @(posedge clock);
    chk("rx level high", 1, rx_level);
  endtask

  task automatic t_sync;
    int         n;
    int         t;
    logic       pv;
    logic [7:0] got;
    wb(1'b1, A_RXC, 8'hA0);
    wb(1'b1, A_DIV, 8'h01);
    wb(1'b1, A_TXC, 8'hB4);
    wb(1'b1, A_TXD, 8'h96);
    n = 0;
    pv = ck_o;
    repeat (100) begin
      @(posedge clock);
      if (ck_o === 1'b1 && pv === 1'b0) n++;
      pv = ck_o;
    end
    chk("clock edges while receive enabled", 0, n);
    wb(1'b1, A_RXC, 8'h80);
    got = '0;
    for (int i = 0; i < 8; i++) begin
      t = 0;
      do begin
        pv = ck_o;
        @(posedge clock);
        t++;
      end while (!(ck_o === 1'b1 && pv === 1'b0) && t < 2000);
      got[i] = dt_o;
      if (i > 0) chk("sync clock period", 8, t);
    end
    chk("clock pin driven", 1, ck_oe);
    chk("sync data", 8'h96, got);
  endtask

  task automatic t_slave;
    logic [7:0] got;
    wb(1'b1, A_TXC, 8'h30);
    wb(1'b1, A_TXD, 8'h3C);
    repeat (4) @(posedge clock);
    chk("slave leaves clock pin", 0, ck_oe);
    chk("slave drives data pin", 1, dt_oe);
    // The outside clock is slow enough for the three-cycle edge detect to settle.
    for (int i = 0; i < 8; i++) begin
      got[i] = dt_o;
      ck_drv <= 1'b0;
      repeat (6) @(posedge clock);
      ck_drv <= 1'b1;
      repeat (6) @(posedge clock);
    end
    chk("slave data", 8'h3C, got);
    wb(1'b0, A_TXC, 8'h00);
    chk("slave empty flag", 8'h32, q);
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    dat_w = '0;
    rx_drv = 1'b1;
    ck_drv = 1'b1;
    p_nine = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_async_low();
    t_async_high();
    t_majority();
    t_sync();
    t_slave();
    stop_test();
  end
endmodule
